// ==== hw/lcdcmd_pkg.sv ====
package lcdcmd_pkg;

    // ****************************************
    // Register map (word offsets, byte address)
    // ****************************************
    localparam logic [3:0] REG_COMMAND = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_SETTINGS = 4'hC;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_RMW = 8'hE0;
    localparam logic [7:0] CMD_END = 8'hEE;
    localparam logic [7:0] CMD_RESET = 8'hE2;
    localparam logic [7:0] CMD_VOL_MODE = 8'h81;
    localparam logic [7:0] CMD_IND_OFF = 8'hAC;
    localparam logic [7:0] CMD_IND_ON = 8'hAD;
    localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
    localparam logic [7:0] CMD_DISP_ON = 8'hAF;
    localparam logic [7:0] CMD_ALL_NORM = 8'hA4;
    localparam logic [7:0] CMD_ALL_ON = 8'hA5;
    localparam logic [3:0] NIB_COM_SCAN = 4'hC;
    localparam logic [4:0] TOP_POWER = 5'h05;
    localparam logic [4:0] TOP_RATIO = 5'h04;
    localparam logic [3:0] NIB_COL_HI = 4'h1;
    localparam logic [3:0] NIB_COL_LO = 4'h0;

    // ****************************************
    // Reset values and last column
    // ****************************************
    localparam logic [7:0] COL_RESET = 8'h00;
    localparam logic [5:0] VOL_RESET = 6'h20;
    localparam logic [2:0] RATIO_RESET = 3'h0;
    localparam logic [7:0] COL_LAST = 8'h83;

    typedef enum logic [2:0] {
        PS_RUN = 3'b001,
        PS_SLEEP = 3'b010,
        PS_STANDBY = 3'b100
    } lcdcmd_power_e;

    typedef struct packed {
        logic comReverse;
        logic boosterOn;
        logic regulatorOn;
        logic followerOn;
        logic [2:0] ratio;
        logic [5:0] volume;
        logic indicatorOn;
        logic [1:0] indicatorMode;
        logic displayOn;
        logic allOn;
    } lcdcmd_settings_s;

endpackage

// ==== hw/lcdcmd_decoder.sv ====
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
// Behaviour
// - In read-modify-write, data reads keep column; data writes add one, holding at the last column
// - Mode holds until end or reset command; end restores column latched at entry
// - Reset command restores command settings except indicator; display RAM untouched
// - COM scan command bit 3 picks scan order; bits 2..0 ignored
// - Power control bits 2,1,0 enable booster, regulator, follower
// - Ratio command stores 3-bit regulator gain code
// - After volume mode, the next command byte is taken as volume; data bytes still reach RAM
// - Volume byte loads bits 5..0 and ends volume mode
// - 0xAC turns indicator off; 0xAD turns on, locks for next byte
// - Indicator byte stores bits 1..0 and releases the lock
// - Only indicator commands change indicator state
// - Display all ON while display off enters power save
// - Power save is sleep if indicator off, standby if on
// - Power save keeps RAM and still allows RAM access
// - Display all OFF leaves power save
// - Sleep stops oscillator and supply; drivers at ground
// - Standby keeps oscillator and indicator; reset command goes to sleep
module lcdcmd_decoder
    import lcdcmd_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [7:0] ramAddr,
    output logic [7:0] ramWData,
    output logic ramWrite,
    output logic ramRead,
    input wire logic [7:0] ramRData,
    output lcdcmd_settings_s settings,
    output logic oscRun,
    output logic supplyRun,
    output logic dutyDriveRun,
    output logic staticDriveRun
);

    // ****************************************
    // Bus slave
    // ****************************************
    logic reqNew;
    logic isCmd;
    logic isData;
    logic dataWr;
    logic dataRd;
    logic [7:0] wByte;

    assign reqNew = (avs_read | avs_write) & avs_waitrequest;
    assign wByte = avs_writedata[7:0];
    assign isCmd = reqNew & avs_write & (avs_address == REG_COMMAND);
    assign isData = reqNew & (avs_address == REG_DATA);
    assign dataWr = isData & avs_write;
    assign dataRd = isData & avs_read;

    // One wait cycle per access; low for the answer cycle only
    always_ff @(posedge clock) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~reqNew;
        end
    end

    // ****************************************
    // Decoder state
    // ****************************************
    logic volLock_r;
    logic indLock_r;
    logic rmw_r;
    logic [7:0] col_r;
    logic [7:0] colSave_r;
    lcdcmd_power_e power_r;
    lcdcmd_settings_s set_r;
    logic cmdOk;
    logic swReset;

    function automatic logic [7:0] colInc(input logic [7:0] c);
        colInc = (c == COL_LAST) ? c : c + 8'h01;
    endfunction

    // A pending two-byte command swallows the next command byte
    assign cmdOk = isCmd & ~volLock_r & ~indLock_r;
    assign swReset = cmdOk & (wByte == CMD_RESET);

    always_ff @(posedge clock) begin
        if (srst) begin
            volLock_r <= 1'b0;
            indLock_r <= 1'b0;
        end else if (isCmd & volLock_r) begin
            volLock_r <= 1'b0;
        end else if (isCmd & indLock_r) begin
            indLock_r <= 1'b0;
        end else if (cmdOk) begin
            volLock_r <= (wByte == CMD_VOL_MODE);
            indLock_r <= (wByte == CMD_IND_ON);
        end
    end

    // ****************************************
    // Column address and read-modify-write
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            rmw_r <= 1'b0;
            col_r <= COL_RESET;
            colSave_r <= COL_RESET;
        end else if (swReset) begin
            rmw_r <= 1'b0;
            col_r <= COL_RESET;
        end else if (cmdOk & (wByte == CMD_RMW)) begin
            rmw_r <= 1'b1;
            colSave_r <= col_r;
        end else if (cmdOk & (wByte == CMD_END) & rmw_r) begin
            rmw_r <= 1'b0;
            col_r <= colSave_r;
        end else if (cmdOk & (wByte[7:4] == NIB_COL_HI)) begin
            col_r <= {wByte[3:0], col_r[3:0]};
        end else if (cmdOk & (wByte[7:4] == NIB_COL_LO)) begin
            col_r <= {col_r[7:4], wByte[3:0]};
        end else if (dataWr) begin
            col_r <= colInc(col_r);
        end else if (dataRd & ~rmw_r) begin
            col_r <= colInc(col_r);
        end
    end

    // RAM port works in every power state
    always_ff @(posedge clock) begin
        if (srst) begin
            ramAddr <= COL_RESET;
            ramWData <= 8'h00;
            ramWrite <= 1'b0;
            ramRead <= 1'b0;
        end else begin
            ramAddr <= col_r;
            ramWData <= wByte;
            ramWrite <= dataWr;
            ramRead <= dataRd;
        end
    end

    // ****************************************
    // Settings
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            set_r <= '0;
            set_r.volume <= VOL_RESET;
            set_r.ratio <= RATIO_RESET;
        end else if (isCmd & volLock_r) begin
            set_r.volume <= wByte[5:0];
        end else if (isCmd & indLock_r) begin
            set_r.indicatorMode <= wByte[1:0];
        end else if (swReset) begin
            // Indicator survives the command reset
            set_r.comReverse <= 1'b0;
            set_r.boosterOn <= 1'b0;
            set_r.regulatorOn <= 1'b0;
            set_r.followerOn <= 1'b0;
            set_r.ratio <= RATIO_RESET;
            set_r.volume <= VOL_RESET;
            set_r.displayOn <= 1'b0;
            set_r.allOn <= 1'b0;
        end else if (cmdOk) begin
            if (wByte[7:4] == NIB_COM_SCAN) begin
                set_r.comReverse <= wByte[3];
            end
            if (wByte[7:3] == TOP_POWER) begin
                set_r.boosterOn <= wByte[2];
                set_r.regulatorOn <= wByte[1];
                set_r.followerOn <= wByte[0];
            end
            if (wByte[7:3] == TOP_RATIO) begin
                set_r.ratio <= wByte[2:0];
            end
            if (wByte == CMD_IND_OFF) begin
                set_r.indicatorOn <= 1'b0;
            end
            if (wByte == CMD_IND_ON) begin
                set_r.indicatorOn <= 1'b1;
            end
            if (wByte == CMD_DISP_ON) begin
                set_r.displayOn <= 1'b1;
            end
            if (wByte == CMD_DISP_OFF) begin
                set_r.displayOn <= 1'b0;
            end
            if (wByte == CMD_ALL_ON) begin
                set_r.allOn <= 1'b1;
            end
            if (wByte == CMD_ALL_NORM) begin
                set_r.allOn <= 1'b0;
            end
        end
    end

    // ****************************************
    // Power save
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            power_r <= PS_RUN;
        end else begin
            case (power_r)
                PS_RUN: begin
                    if (cmdOk & (wByte == CMD_ALL_ON) & ~set_r.displayOn) begin
                        power_r <= set_r.indicatorOn ? PS_STANDBY
                                                     : PS_SLEEP;
                    end
                end
                PS_SLEEP: begin
                    if (cmdOk & (wByte == CMD_ALL_NORM)) begin
                        power_r <= PS_RUN;
                    end
                end
                PS_STANDBY: begin
                    if (cmdOk & (wByte == CMD_ALL_NORM)) begin
                        power_r <= PS_RUN;
                    end else if (swReset) begin
                        power_r <= PS_SLEEP;
                    end
                end
                default: begin
                    power_r <= PS_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            oscRun <= 1'b1;
            supplyRun <= 1'b1;
            dutyDriveRun <= 1'b1;
            staticDriveRun <= 1'b1;
            settings <= '0;
            settings.volume <= VOL_RESET;
            settings.ratio <= RATIO_RESET;
        end else begin
            oscRun <= (power_r != PS_SLEEP);
            supplyRun <= (power_r == PS_RUN);
            dutyDriveRun <= (power_r == PS_RUN);
            staticDriveRun <= (power_r != PS_SLEEP);
            settings <= set_r;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            avs_readdata <= 32'h00000000;
        end else if (reqNew & avs_read) begin
            case (avs_address)
                REG_DATA: avs_readdata <= {24'h000000, ramRData};
                REG_STATUS: avs_readdata <= {24'h000000, rmw_r, volLock_r,
                                             indLock_r, 2'b00, power_r};
                REG_SETTINGS: avs_readdata <= {24'h000000, set_r.displayOn,
                                               set_r.allOn, set_r.volume};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_volCmd;
        isCmd & ~volLock_r & ~indLock_r & (wByte == CMD_VOL_MODE);
    endsequence

    sequence s_indCmd;
        cmdOk & (wByte == CMD_IND_ON);
    endsequence

    a_vol_lock: assert property (
        @(posedge clock) disable iff (srst)
        s_volCmd |=> volLock_r)
        else $error("volume lock not set");
    a_vol_load: assert property (
        @(posedge clock) disable iff (srst)
        (isCmd & volLock_r) |=> (set_r.volume == $past(wByte[5:0]))
        && !volLock_r)
        else $error("volume byte not loaded");
    a_rmw_read: assert property (
        @(posedge clock) disable iff (srst)
        (dataRd & rmw_r & !isCmd) |=> $stable(col_r))
        else $error("column moved on read");
    a_rmw_end: assert property (
        @(posedge clock) disable iff (srst)
        (cmdOk & wByte == CMD_END & rmw_r) |=> col_r == $past(colSave_r))
        else $error("column not restored");
    a_scan_dir: assert property (
        @(posedge clock) disable iff (srst)
        (cmdOk & wByte[7:4] == NIB_COM_SCAN) |=>
        set_r.comReverse == $past(wByte[3]))
        else $error("scan order wrong");
    a_pwr_bits: assert property (
        @(posedge clock) disable iff (srst)
        (cmdOk & wByte[7:3] == TOP_POWER & !swReset) |=>
        {set_r.boosterOn, set_r.regulatorOn, set_r.followerOn}
        == $past(wByte[2:0]))
        else $error("power bits wrong");
    a_save_enter: assert property (
        @(posedge clock) disable iff (srst)
        (power_r == PS_RUN & cmdOk & wByte == CMD_ALL_ON & !set_r.displayOn)
        |=> power_r == ($past(set_r.indicatorOn) ? PS_STANDBY : PS_SLEEP))
        else $error("power save mode wrong");
    a_sleep_out: assert property (
        @(posedge clock) disable iff (srst)
        (power_r == PS_SLEEP) |=> !oscRun && !supplyRun && !dutyDriveRun)
        else $error("oscillator runs in sleep");
    a_standby_run: assert property (
        @(posedge clock) disable iff (srst)
        (power_r == PS_STANDBY) |=> oscRun && staticDriveRun
        && !supplyRun && !dutyDriveRun)
        else $error("standby drive state wrong");
    a_standby_rst: assert property (
        @(posedge clock) disable iff (srst)
        (power_r == PS_STANDBY) & swReset |=> power_r == PS_SLEEP)
        else $error("reset in standby did not sleep");
    a_save_exit: assert property (
        @(posedge clock) disable iff (srst)
        (power_r != PS_RUN) & cmdOk & (wByte == CMD_ALL_NORM)
        |=> power_r == PS_RUN)
        else $error("power save not left");
    a_ind_lock: assert property (
        @(posedge clock) disable iff (srst)
        s_indCmd |=> indLock_r && set_r.indicatorOn)
        else $error("indicator lock not set");
    a_ind_load: assert property (
        @(posedge clock) disable iff (srst)
        (isCmd & indLock_r) |=> (set_r.indicatorMode == $past(wByte[1:0]))
        && !indLock_r)
        else $error("indicator byte not loaded");
    a_ind_hold: assert property (
        @(posedge clock) disable iff (srst)
        !(isCmd & indLock_r) & !(cmdOk & ((wByte == CMD_IND_ON)
        | (wByte == CMD_IND_OFF))) |=> $stable(set_r.indicatorOn)
        && $stable(set_r.indicatorMode))
        else $error("indicator changed by other command");
    a_ratio_code: assert property (
        @(posedge clock) disable iff (srst)
        (cmdOk & wByte[7:3] == TOP_RATIO) |=> set_r.ratio == $past(wByte[2:0]))
        else $error("ratio code wrong");
    a_data_only: assert property (
        @(posedge clock) disable iff (srst)
        isData |=> $stable(set_r) && $stable(volLock_r) && $stable(indLock_r))
        else $error("data byte acted as command");
    a_col_step: assert property (
        @(posedge clock) disable iff (srst)
        dataWr & (col_r != COL_LAST) |=> col_r == $past(col_r) + 8'h01)
        else $error("column not stepped on write");
    a_cmd_reset: assert property (
        @(posedge clock) disable iff (srst)
        swReset |=> (col_r == COL_RESET) && !rmw_r
        && (set_r.volume == VOL_RESET))
        else $error("reset command incomplete");

endmodule

// ==== verif/lcdcmd_ram_model.sv ====
`timescale 1ns/1ps
// ****
// Display RAM behind the decoder
// ****
module lcdcmd_ram_model (
    input wire logic clock,
    input wire logic [7:0] ramAddr,
    input wire logic [7:0] ramWData,
    input wire logic ramWrite,
    output logic [7:0] ramRData
);
    logic [7:0] mem [256];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
    end
    // Contents kept whatever the power state
    always @(posedge clock) begin
        if (ramWrite) begin
            mem[ramAddr] <= ramWData;
        end
    end
    assign ramRData = mem[ramAddr];
endmodule

// ==== verif/lcd_driver_command_decoder_bench.sv ====
`timescale 1ns/1ps
module lcd_driver_command_decoder_bench
    import lcdcmd_pkg::*;
;
    logic clock = 1'h0;
    logic srst = 1'h1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] ramAddr, ramWData, ramRData, expCol, savedCol, rd;
    logic ramWrite, ramRead, oscRun, supplyRun, dutyDriveRun, staticDriveRun;
    logic volLock, indLock, rmw;
    logic [7:0] bmem [256];
    lcdcmd_settings_s settings, expSet;
    lcdcmd_power_e expPs;
    int errCount = 0;
    int compares = 0;
    int seed = 17755;
    int r;
    logic [7:0] rdPulses, expRd;

    initial forever #5 clock = ~clock;

    always @(posedge clock) begin
        rdPulses <= srst ? 8'h00 : rdPulses + {7'h00, ramRead};
    end

    lcdcmd_decoder u_dut (.clock(clock), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ramAddr(ramAddr), .ramWData(ramWData), .ramWrite(ramWrite),
        .ramRead(ramRead), .ramRData(ramRData), .settings(settings),
        .oscRun(oscRun), .supplyRun(supplyRun),
        .dutyDriveRun(dutyDriveRun), .staticDriveRun(staticDriveRun));
    lcdcmd_ram_model u_ram (.clock(clock), .ramAddr(ramAddr),
        .ramWData(ramWData), .ramWrite(ramWrite), .ramRData(ramRData));

    // ****
    // Bus cycles and comparisons
    // ****
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'h0);
        q = avs_readdata[7:0];
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask

    task automatic chkByte(input logic [7:0] got, input logic [7:0] want);
        compares++;
        if (got !== want) begin
            errCount++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic chkSet(input lcdcmd_settings_s got, want);
        compares++;
        if (got !== want) begin
            errCount++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic cmd(input logic [7:0] b);
        bus(1'h1, REG_COMMAND, b, rd);
        if (volLock) begin
            expSet.volume = b[5:0];
            volLock = 1'h0;
        end else if (indLock) begin
            expSet.indicatorMode = b[1:0];
            indLock = 1'h0;
        end else begin
            casez (b)
                8'hC?: expSet.comReverse = b[3];
                8'h2?: begin
                    if (b[3]) begin
                        expSet.boosterOn = b[2];
                        expSet.regulatorOn = b[1];
                        expSet.followerOn = b[0];
                    end else begin
                        expSet.ratio = b[2:0];
                    end
                end
                8'h1?: expCol[7:4] = b[3:0];
                8'h0?: expCol[3:0] = b[3:0];
                CMD_VOL_MODE: volLock = 1'h1;
                CMD_IND_OFF: expSet.indicatorOn = 1'h0;
                CMD_IND_ON: {expSet.indicatorOn, indLock} = 2'h3;
                CMD_DISP_OFF, CMD_DISP_ON: expSet.displayOn = b[0];
                CMD_ALL_NORM: begin
                    expSet.allOn = 1'h0;
                    expPs = PS_RUN;
                end
                CMD_ALL_ON: begin
                    expSet.allOn = 1'h1;
                    if (!expSet.displayOn && expPs == PS_RUN) begin
                        expPs = expSet.indicatorOn ? PS_STANDBY : PS_SLEEP;
                    end
                end
                CMD_RMW: {rmw, savedCol} = {1'h1, expCol};
                CMD_END: if (rmw) {rmw, expCol} = {1'h0, savedCol};
                CMD_RESET: begin
                    expSet = '{volume: VOL_RESET,
                        indicatorOn: expSet.indicatorOn,
                        indicatorMode: expSet.indicatorMode, default: '0};
                    expCol = COL_RESET;
                    rmw = 1'h0;
                    if (expPs == PS_STANDBY) expPs = PS_SLEEP;
                end
                default: ;
            endcase
        end
    endtask

    task automatic dataWr(input logic [7:0] d);
        bus(1'h1, REG_DATA, d, rd);
        bmem[expCol] = d;
        if (expCol < COL_LAST) expCol++;
    endtask

    task automatic dataRd();
        bus(1'h0, REG_DATA, 8'h00, rd);
        chkByte(rd, bmem[expCol]);
        expRd = expRd + 8'h01;
        if (!rmw && expCol < COL_LAST) expCol++;
    endtask

    task automatic checkAll();
        logic [3:0] run;
        repeat (2) @(posedge clock);
        chkSet(settings, expSet);
        chkByte(ramAddr, expCol);
        chkByte(rdPulses, expRd);
        case (expPs)
            PS_RUN: run = 4'hF;
            PS_SLEEP: run = 4'h0;
            default: run = 4'h9;
        endcase
        chkByte({4'h0, oscRun, supplyRun, dutyDriveRun, staticDriveRun},
            {4'h0, run});
        bus(1'h0, REG_STATUS, 8'h00, rd);
        chkByte(rd, {rmw, volLock, indLock, 2'h0, expPs});
        bus(1'h0, REG_SETTINGS, 8'h00, rd);
        chkByte(rd, {expSet.displayOn, expSet.allOn, expSet.volume});
    endtask

    task automatic wrapUp();
        if (errCount == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        errCount++;
        wrapUp();
    end

    // ****
    // Scenarios
    // ****
    initial begin
        expSet = '{volume: VOL_RESET, default: '0};
        expPs = PS_RUN;
        {expCol, savedCol, rmw, volLock, indLock} = '0;
        expRd = 8'h00;
        for (int i = 0; i < 256; i++) bmem[i] = 8'h00;
        repeat (10) @(posedge clock);
        srst <= 1'h0;
        checkAll();
        bus(1'h0, 4'h2, 8'h00, rd);
        chkByte(rd, 8'h00);
        bus(1'h1, REG_SETTINGS, 8'hFF, rd);
        for (int i = 0; i < 8; i++) begin
            cmd({5'h05, i[2:0]});
            cmd({5'h04, i[2:0]});
            checkAll();
        end
        for (int i = 0; i < 30; i++) begin
            r = $random(seed);
            case (r[10:8] % 5)
                0: cmd({4'hC, r[3:0]});
                1: cmd({5'h05, r[2:0]});
                2: cmd({5'h04, r[2:0]});
                3: begin cmd(CMD_VOL_MODE); cmd(r[7:0]); end
                default: begin cmd(CMD_IND_ON); cmd(r[7:0]); end
            endcase
            checkAll();
        end
        cmd(CMD_VOL_MODE);
        dataWr(CMD_RESET);
        checkAll();
        cmd(CMD_RESET);
        cmd(CMD_IND_ON);
        cmd(CMD_IND_OFF);
        cmd(CMD_DISP_OFF);
        cmd(CMD_ALL_ON);
        checkAll();
        dataWr(r[15:8]);
        cmd(CMD_RESET);
        checkAll();
        cmd(8'h10);
        cmd(8'h00);
        dataRd();
        cmd(CMD_ALL_NORM);
        checkAll();
        cmd(CMD_IND_OFF);
        cmd(CMD_ALL_ON);
        checkAll();
        cmd(CMD_ALL_NORM);
        // Column held by read, stepped by write, no column set meanwhile
        cmd({5'h02, r[14:12]});
        cmd({4'h0, r[3:0]});
        cmd(CMD_RMW);
        dataRd();
        dataWr(r[23:16]);
        dataRd();
        dataWr(r[31:24]);
        checkAll();
        cmd(CMD_END);
        checkAll();
        dataRd();
        cmd(8'h18);
        cmd(8'h02);
        repeat (3) dataWr(r[7:0]);
        checkAll();
        wrapUp();
    end
endmodule
